// ---- pkg/slio_pkg.sv ----
// types for the secondary latency timer and io window block
package slio_pkg;
    // configuration access from the primary side
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [3:0] be_n;
        logic [31:0] wdata;
    } slio_cfg_t;
    // master state on the secondary bus
    typedef enum logic [1:0] {slio_idle, slio_burst, slio_last} slio_state_t;
endpackage

// ---- pkg/slio_regs.svh ----
// register offsets, field positions, reset values and timing counts for the latency/io window block
// Overview of operation
// R1: secondary hold counter counts clocks from our frame assertion, value in bits 31:27.
// R2: only latency bits 31:27 writable; timer value applies in steps of eight clocks.
// R3: latency bits 26:24 read zero, forcing eight-cycle increments.
// R4: value zero with grant removed ends transaction after first data phase, except write-invalidate.
// R5: counter expiry with grant removed ends transaction at next data phase boundary.
// R6: io base bits 3:0 and limit bits 11:8 read 0x1, 32-bit decoding.
// R7: io base bits 7:4 give window bottom bits 15:12; bottom bits 11:0 zero.
// R8: io limit bits 15:12 give window top bits 15:12; top bits 11:0 ones.
// R9: window bottom bits 31:16 come from the separate base upper register.
// R10: window top bits 31:16 come from the separate limit upper register.
// R11: io addresses compared against bottom and top decide forwarding.
// R12: io window aligned to 4 KB and sized in 4 KB steps.
// R13: software programs io base and limit before relying on forwarding.
`ifndef SLIO_REGS_SVH
`define SLIO_REGS_SVH
`define SLIO_OFS_LAT 8'h18
`define SLIO_OFS_IO 8'h1c
`define SLIO_LAT_HI 31
`define SLIO_LAT_LO 27
`define SLIO_LAT_RST 5'h00
`define SLIO_LAT_STEP_SH 3
`define SLIO_IO_IND 4'h1
`define SLIO_IOB_HI 7
`define SLIO_IOB_LO 4
`define SLIO_IOL_HI 15
`define SLIO_IOL_LO 12
`define SLIO_IO_RST 4'h0
`define SLIO_PAGE_ZERO 12'h000
`define SLIO_PAGE_ONES 12'hfff
`define SLIO_BE_LAT 3
`define SLIO_BE_IOB 0
`define SLIO_BE_IOL 1
`endif

// ---- rtl/slio_core.sv ----
// secondary latency timer, io window registers and io forward decode
`timescale 1ns/1ns
`include "slio_regs.svh"
module slio_core
    import slio_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire slio_cfg_t cfg,
    output logic [31:0] cfg_rdata,
    input wire logic [15:0] io_base_upper,
    input wire logic [15:0] io_limit_upper,
    input wire logic [31:0] io_addr,
    output logic io_hit,
    input wire logic mst_start,
    input wire logic mst_data_done,
    input wire logic mst_mwi,
    input wire logic sec_gnt_n_pin,
    output logic mst_stop,
    output logic [31:0] win_bottom,
    output logic [31:0] win_top
);
    logic [4:0] lat_val;
    logic [3:0] iob_val;
    logic [3:0] iol_val;
    logic gnt_meta_n;
    logic gnt_sync_n;
    logic [CNT_W-1:0] lat_cnt;
    logic expired;
    slio_state_t state;
    slio_state_t next_state;

    // byte enables are active low, per byte lane
    function automatic logic lane_on(input logic [3:0] be_n, input int lane);
        lane_on = ~be_n[lane];
    endfunction

    wire logic wr_lat = cfg.wr && cfg.addr == `SLIO_OFS_LAT && lane_on(cfg.be_n, `SLIO_BE_LAT);
    wire logic wr_iob = cfg.wr && cfg.addr == `SLIO_OFS_IO && lane_on(cfg.be_n, `SLIO_BE_IOB);
    wire logic wr_iol = cfg.wr && cfg.addr == `SLIO_OFS_IO && lane_on(cfg.be_n, `SLIO_BE_IOL);

    // configuration writes; only the writable fields are stored
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lat_val <= `SLIO_LAT_RST;
            iob_val <= `SLIO_IO_RST;
            iol_val <= `SLIO_IO_RST;
        end
        else
        begin
            if (wr_lat)
                lat_val <= cfg.wdata[`SLIO_LAT_HI:`SLIO_LAT_LO]; // R2
            if (wr_iob)
                iob_val <= cfg.wdata[`SLIO_IOB_HI:`SLIO_IOB_LO]; // R7
            if (wr_iol)
                iol_val <= cfg.wdata[`SLIO_IOL_HI:`SLIO_IOL_LO]; // R8
        end
    end

    // read mux; other offsets of this block read zero, other bytes there belong elsewhere
    wire logic [31:0] rd_lat = {lat_val, 3'h0, 24'h000000}; // R1 R3
    wire logic [31:0] rd_io = {16'h0000, iol_val, `SLIO_IO_IND, iob_val, `SLIO_IO_IND}; // R6
    wire logic [31:0] next_rdata = (cfg.addr == `SLIO_OFS_LAT) ? rd_lat :
                                   (cfg.addr == `SLIO_OFS_IO) ? rd_io : 32'h00000000;

    // read data registered, valid one cycle after the address
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cfg_rdata <= 32'h00000000;
        else
            cfg_rdata <= next_rdata;
    end

    // window edges: low 12 bits forced, so always 4 KB aligned
    wire logic [31:0] next_bottom = {io_base_upper, iob_val, `SLIO_PAGE_ZERO}; // R7 R9 R12
    wire logic [31:0] next_top = {io_limit_upper, iol_val, `SLIO_PAGE_ONES}; // R8 R10 R12

    // edges and hit registered; decode is one cycle behind the address
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            win_bottom <= 32'h00000000;
            win_top <= 32'h00000000;
            io_hit <= 1'b0;
        end
        else
        begin
            win_bottom <= next_bottom;
            win_top <= next_top;
            io_hit <= io_addr >= next_bottom && io_addr <= next_top; // R11
        end
    end

    // grant pin comes from the bus; two flops before use
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gnt_meta_n <= 1'b1;
            gnt_sync_n <= 1'b1;
        end
        else
        begin
            gnt_meta_n <= sec_gnt_n_pin;
            gnt_sync_n <= gnt_meta_n;
        end
    end

    // timer load: value times eight clocks
    wire logic [CNT_W-1:0] lat_load = CNT_W'({lat_val, 3'h0}); // R2
    assign expired = lat_cnt == '0;
    wire logic stop_cond = expired && gnt_sync_n && !mst_mwi; // R4 R5

    // master state: burst from frame assertion until a stop at a data phase boundary
    always_comb
    begin
        next_state = state;
        case (state)
            slio_idle:
                if (mst_start)
                    next_state = slio_burst;
            slio_burst:
                if (mst_data_done && stop_cond)
                    next_state = slio_last;
            slio_last:
                next_state = slio_idle;
            default:
                next_state = slio_idle;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= slio_idle;
            lat_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            if (mst_start && state == slio_idle)
                lat_cnt <= lat_load; // R1
            else if (!expired)
                lat_cnt <= lat_cnt - CNT_W'(1); // R1
        end
    end

    // stop request: at a data boundary once expired with grant gone
    assign mst_stop = state == slio_burst && mst_data_done && stop_cond; // R4 R5

    // helper for checks only: clocks since our frame went out, and the value armed then
    logic [CNT_W:0] frame_age;
    logic [CNT_W-1:0] armed_load;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            frame_age <= '0;
            armed_load <= '0;
        end
        else if (state == slio_idle && mst_start)
        begin
            frame_age <= '0;
            armed_load <= lat_load;
        end
        else if (!frame_age[CNT_W])
            frame_age <= frame_age + (CNT_W+1)'(1);
    end

    // checks below watch only what this block drives
    // registered outputs hold reset values one edge past release, so
    // checks that read them are gated by the previous reset level

    // zero value: first data phase ends it once the grant is gone
    zero_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        state == slio_burst && lat_val == 5'h00 && gnt_sync_n && !mst_mwi && mst_data_done
        |-> mst_stop) else $error("zero timer did not stop"); // R4

    // write and invalidate is never cut short
    mwi_nostop_a: assert property (@(posedge clk) disable iff (!resetn)
        mst_mwi |-> !mst_stop) else $error("write invalidate stopped"); // R4

    // counter armed with value times eight on our frame
    count_load_a: assert property (@(posedge clk) disable iff (!resetn)
        state == slio_idle && mst_start |=> lat_cnt == lat_load) else $error("bad load"); // R1

    // counter steps down by one each clock
    count_step_a: assert property (@(posedge clk) disable iff (!resetn)
        !(state == slio_idle && mst_start) && lat_cnt != '0 |=> lat_cnt == $past(lat_cnt) - 1)
        else $error("counter not stepping"); // R1

    // an expired counter rests at zero until the next frame
    count_rest_a: assert property (@(posedge clk) disable iff (!resetn)
        lat_cnt == '0 && !(state == slio_idle && mst_start) |=> lat_cnt == '0)
        else $error("counter left zero"); // R1

    // counter plus elapsed clocks equals the armed value while it runs
    count_age_a: assert property (@(posedge clk) disable iff (!resetn)
        state == slio_burst && frame_age <= {1'b0, armed_load} |-> lat_cnt + frame_age == armed_load)
        else $error("counter off frame time"); // R1 R2

    // no stop before the armed number of clocks has passed
    stop_early_a: assert property (@(posedge clk) disable iff (!resetn)
        mst_stop |-> frame_age >= {1'b0, armed_load})
        else $error("stopped too early"); // R1 R5

    // stop only at a data phase boundary of our own burst, counter expired
    stop_where_a: assert property (@(posedge clk) disable iff (!resetn)
        mst_stop |-> state == slio_burst && mst_data_done && lat_cnt == '0)
        else $error("stop outside boundary"); // R5

    // after a stop the bus is released: one last cycle, then idle
    stop_release_a: assert property (@(posedge clk) disable iff (!resetn)
        mst_stop |=> state == slio_last ##1 state == slio_idle)
        else $error("bus not released"); // R5

    // a frame from idle always opens a burst
    start_burst_a: assert property (@(posedge clk) disable iff (!resetn)
        state == slio_idle && mst_start |=> state == slio_burst) else $error("no burst"); // R1

    // grant still held: never stop
    grant_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !gnt_sync_n |-> !mst_stop) else $error("stopped while granted"); // R5

    // grant pin reaches the stop logic exactly two clocks late
    gnt_sync_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |-> gnt_sync_n == $past(sec_gnt_n_pin, 2)) else $error("grant sync depth"); // R5

    // latency write stores the top five bits of the data word
    lat_wr_a: assert property (@(posedge clk) disable iff (!resetn)
        wr_lat |=> lat_val == $past(cfg.wdata[`SLIO_LAT_HI:`SLIO_LAT_LO]))
        else $error("latency write"); // R2

    // latency field holds when not written
    lat_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        !wr_lat |=> $stable(lat_val)) else $error("latency changed"); // R2

    // window fields hold when not written
    io_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        !wr_iob && !wr_iol |=> $stable(iob_val) && $stable(iol_val))
        else $error("window field changed"); // R7 R8

    // latency low bits always read zero
    lat_low_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.addr == `SLIO_OFS_LAT |=> cfg_rdata[26:24] == 3'h0) else $error("latency low bits"); // R3

    // latency read returns the field on top and zeros below
    lat_read_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && cfg.addr == `SLIO_OFS_LAT |=> cfg_rdata[31:27] == $past(lat_val)
        && cfg_rdata[23:0] == 24'h000000) else $error("latency read"); // R1 R3

    // both indicator nibbles read one
    io_ind_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && cfg.addr == `SLIO_OFS_IO |=> cfg_rdata[3:0] == 4'h1 && cfg_rdata[11:8] == 4'h1)
        else $error("io indicator wrong"); // R6

    // io read returns both fields in place, upper half zero here
    io_read_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && cfg.addr == `SLIO_OFS_IO |=> cfg_rdata[7:4] == $past(iob_val)
        && cfg_rdata[15:12] == $past(iol_val) && cfg_rdata[31:16] == 16'h0000)
        else $error("io read"); // R7 R8

    // offsets outside this block read zero
    rd_other_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.addr != `SLIO_OFS_LAT && cfg.addr != `SLIO_OFS_IO |=> cfg_rdata == 32'h00000000)
        else $error("unmapped read");

    // window edges fall on page boundaries once out of reset
    win_align_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) |-> win_bottom[11:0] == 12'h000 && win_top[11:0] == 12'hfff)
        else $error("misaligned"); // R12

    // upper halves come straight from the upper registers
    upper_src_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> win_bottom[31:16] == $past(io_base_upper) && win_top[31:16] == $past(io_limit_upper))
        else $error("upper bits wrong"); // R9 R10

    // address in the bottom page hits exactly when it is not above the top
    hit_dec_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && io_addr[31:12] == {io_base_upper, iob_val}
        |=> io_hit == (win_top >= $past(io_addr))) else $error("bad hit decode"); // R11

    // addresses below the bottom or above the top are never forwarded
    hit_out_a: assert property (@(posedge clk) disable iff (!resetn)
        io_addr[31:12] < {io_base_upper, iob_val} || io_addr[31:12] > {io_limit_upper, iol_val}
        |=> !io_hit) else $error("hit outside window"); // R11 R12

    // an address inside the window is forwarded
    hit_in_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && io_addr[31:12] >= {io_base_upper, iob_val}
        && io_addr[31:12] <= {io_limit_upper, iol_val} |=> io_hit) else $error("missed hit"); // R11 R12

    // base write reaches the bottom edge two clocks later
    base_wr_a: assert property (@(posedge clk) disable iff (!resetn)
        wr_iob |=> ##1 win_bottom[15:12] == $past(cfg.wdata[7:4], 2)) else $error("base write"); // R7

    // limit write reaches the top edge two clocks later
    limit_wr_a: assert property (@(posedge clk) disable iff (!resetn)
        wr_iol |=> ##1 win_top[15:12] == $past(cfg.wdata[15:12], 2)) else $error("limit write"); // R8
endmodule

// ---- testbench/secondary_latency_and_io_window_tb.sv ----
// self-checking bench for the latency timer and io window block
`timescale 1ns/1ns
module secondary_latency_and_io_window_tb;
    import slio_pkg::*;
    logic clk = 0, resetn = 0, mst_start = 0, mst_mwi = 0, gnt_want = 0, go = 0, slow = 0;
    slio_cfg_t cfg = '0;
    logic [15:0] bu = '0, lu = '0;
    logic [31:0] io_addr = '0, rdat, wb, wt, lo, hi, a;
    logic io_hit, mst_stop, gnt_n, done;
    logic [3:0] b, l;
    logic [4:0] lat;
    int error_cnt = 0, num_checks = 0, cyc = 0, n, i, k;
    slio_core dut (.clk(clk), .resetn(resetn), .cfg(cfg), .cfg_rdata(rdat),
        .io_base_upper(bu), .io_limit_upper(lu), .io_addr(io_addr), .io_hit(io_hit),
        .mst_start(mst_start), .mst_data_done(done), .mst_mwi(mst_mwi),
        .sec_gnt_n_pin(gnt_n), .mst_stop(mst_stop), .win_bottom(wb), .win_top(wt));
    slio_sec_bus sec (.clk(clk), .resetn(resetn), .gnt_want(gnt_want), .go(go),
        .slow(slow), .sec_gnt_n_pin(gnt_n), .mst_data_done(done));
    always #4 clk = ~clk;
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    task finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        cfg <= '{1'b1, ad, be, d};
        @(posedge clk);
        cfg <= '{1'b0, ad, 4'hf, 32'h0};
    endtask
    // read data is registered: sample one edge after the address goes out
    task rd(input logic [7:0] ad, input logic [31:0] exp);
        @(posedge clk);
        cfg <= '{1'b0, ad, 4'hf, 32'h0};
        @(posedge clk);
        #1 chk("cfg_rdata", rdat, exp);
    endtask
    // blk 1 holds write-invalidate, blk 2 holds the grant, both until cycle 20
    task run(input logic [4:0] lt, input logic sl, input int blk);
        @(posedge clk);
        mst_mwi <= (blk == 1);
        gnt_want <= (blk == 2);
        wr(8'h18, 4'h7, {lt, 27'h0});
        @(posedge clk);
        mst_start <= 1'b1;
        slow <= sl;
        @(posedge clk);
        mst_start <= 1'b0;
        go <= 1'b1;
        n = 1;
        #1;
        while (n < 300 && mst_stop !== 1'b1)
        begin
            @(posedge clk);
            n++;
            if (n == 20)
            begin
                mst_mwi <= 1'b0;
                gnt_want <= 1'b0;
            end
            #1;
        end
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        void'($urandom(32'h746a));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h18, 32'h0);
        rd(8'h1c, 32'h0101);
        rd(8'h20, 32'h0);
        wr(8'h18, 4'h0, 32'hffffffff);
        rd(8'h18, 32'hf8000000);
        for (i = 0; i < 5; i++)
        begin
            b = 4'($urandom);
            l = 4'($urandom);
            a = $urandom;
            wr(8'h1c, 4'hc, {a[31:16], l, a[11:8], b, a[3:0]});
            @(posedge clk);
            bu <= 16'($urandom);
            lu <= 16'($urandom % 2);
            @(posedge clk);
            lu <= bu + lu;
            repeat (2) @(posedge clk);
            lo = {bu, b, 12'h000};
            hi = {lu, l, 12'hfff};
            #1 chk("win_bottom", wb, lo);
            chk("win_top", wt, hi);
            rd(8'h1c, {16'h0, l, 4'h1, b, 4'h1});
            for (k = 0; k < 8; k++)
            begin
                a = k == 0 ? lo : k == 1 ? lo - 1 : k == 2 ? hi : k == 3 ? hi + 1
                    : {k[0] ? bu : lu, 16'($urandom)};
                @(posedge clk);
                io_addr <= a;
                @(posedge clk);
                #1 chk("io_hit", io_hit, 32'(a >= lo && a <= hi));
            end
        end
        for (i = 0; i < 6; i++)
        begin
            lat = i < 2 ? 5'h0 : i == 5 ? 5'h1f : 5'($urandom % 4);
            run(lat, i[0], 0);
            chk("stop_cycle", 32'(n), 32'(1 + 8 * int'(lat) + i[0]));
        end
        run(5'h0, 1'b0, 1);
        chk("mwi_hold", 32'(n >= 20 && n <= 26), 32'h1);
        run(5'h1, 1'b1, 2);
        chk("gnt_hold", 32'(n >= 20 && n <= 26), 32'h1);
        finish_test();
    end
endmodule

// ---- testbench/slio_sec_bus.sv ----
// secondary bus partner: arbiter grant and target data phase pacing
`timescale 1ns/1ns
module slio_sec_bus
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic gnt_want,
    input wire logic go,
    input wire logic slow,
    output logic sec_gnt_n_pin,
    output logic mst_data_done
);
    logic ph;
    // grant comes off an arbiter flop, so the bridge must resynchronise it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sec_gnt_n_pin <= 1'b1;
            ph <= 1'b0;
        end
        else
        begin
            sec_gnt_n_pin <= !gnt_want;
            ph <= go ? !ph : 1'b0;
        end
    end
    // a slow target completes a data phase only every other cycle
    assign mst_data_done = go & (!slow | ph);
endmodule
